//--- hdl/acc_correction.sv
// Purpose: Digital correction chain applied to each raw conversion result.
// Assumes: Raw results, selector bits and the coefficients held elsewhere come from logic on clk.
// Notes:   Five pipeline stages; each sample carries its own coefficient choice and polarity mode.
`timescale 1ns/100ps
module acc_correction
(
   input  wire logic                              clk,
   input  wire logic                              rst_n,
   input  wire logic [acc_pkg::ACC_ADDR_W-1:0]    regAddr,
   input  wire logic                              regWrEn,
   input  wire logic [acc_pkg::ACC_DATA_W-1:0]    regWrData,
   input  wire logic                              regRdEn,
   output logic      [acc_pkg::ACC_DATA_W-1:0]    regRdData,
   output logic                                   regRdValid,
   input  wire logic                              calWrEn,
   input  wire logic [acc_pkg::ACC_ADDR_W-1:0]    calWrAddr,
   input  wire logic [acc_pkg::ACC_DATA_W-1:0]    calWrData,
   input  wire logic [acc_pkg::ACC_DATA_W-1:0]    systemOffsetFirst,
   input  wire logic [acc_pkg::ACC_DATA_W-1:0]    selfGain,
   input  wire logic [1:0]                        resultSlotCoefficientChoice,
   input  wire logic                              unipolarBipolarSelect,
   input  wire logic                              selfOffsetBypass,
   input  wire logic                              rawValid,
   input  wire logic signed [acc_pkg::ACC_DATA_W-1:0] rawData,
   output logic                                   resultValid,
   output logic signed [acc_pkg::ACC_DATA_W-1:0]  result
);
   import acc_pkg::*;

   acc_coef_t   coef      [ACC_NUM_COEF];
   acc_coef_t   next_coef [ACC_NUM_COEF];
   acc_coef_t   next_regRdData;
   logic        next_regRdValid;

   acc_stage_t  s1, s2, s3, s4;
   acc_stage_t  next_s1, next_s2, next_s3, next_s4;
   acc_sample_t selfSub, selfScaled, sysSub, sysScaled;
   acc_sample_t sysOffsetSel;
   acc_coef_t   sysGainSel;
   acc_sample_t next_result;
   logic        next_resultValid;
   acc_wide_t   doubled;

   // Coefficient registers. A calibration load in the same cycle as a software
   // write wins, because the calibration result is the newer measurement.
   genvar gi;
   generate
      for (gi = 0; gi < ACC_NUM_COEF; gi++)
      begin : g_coef
         always_comb
         begin
            next_coef[gi] = coef[gi];
            if (regWrEn && regAddr == ACC_ADDR_BASE + ACC_ADDR_W'(gi))
               next_coef[gi] = regWrData;
            if (calWrEn && calWrAddr == ACC_ADDR_BASE + ACC_ADDR_W'(gi))
               next_coef[gi] = calWrData;
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         coef[ACC_IDX_SYSTEM_OFFSET_SECOND] <= ACC_OFFSET_RESET;
         coef[ACC_IDX_SYSTEM_GAIN_FIRST]    <= ACC_GAIN_UNITY;
         coef[ACC_IDX_SYSTEM_GAIN_SECOND]   <= ACC_GAIN_UNITY;
         coef[ACC_IDX_SELF_OFFSET_VALUE]    <= ACC_OFFSET_RESET;
      end
      else
      begin
         coef <= next_coef;
      end
   end

   // Read port: data is captured on a read strobe and held until the next one.
   always_comb
   begin
      next_regRdValid = regRdEn;
      next_regRdData  = regRdData;
      if (regRdEn)
      begin
         if (regAddr == ACC_ADDR_SYSTEM_OFFSET_SECOND)
            next_regRdData = coef[ACC_IDX_SYSTEM_OFFSET_SECOND];
         else if (regAddr == ACC_ADDR_SYSTEM_GAIN_FIRST)
            next_regRdData = coef[ACC_IDX_SYSTEM_GAIN_FIRST];
         else if (regAddr == ACC_ADDR_SYSTEM_GAIN_SECOND)
            next_regRdData = coef[ACC_IDX_SYSTEM_GAIN_SECOND];
         else if (regAddr == ACC_ADDR_SELF_OFFSET_VALUE)
            next_regRdData = coef[ACC_IDX_SELF_OFFSET_VALUE];
         else
            next_regRdData = ACC_READ_UNMAPPED;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         regRdData  <= ACC_READ_UNMAPPED;
         regRdValid <= 1'b0;
      end
      else
      begin
         regRdData  <= next_regRdData;
         regRdValid <= next_regRdValid;
      end
   end

   // Stage 1: self offset, read as two's complement regardless of coding.
   acc_sat_sub u_selfSub
   (
      .minuend    (rawData),
      .subtrahend ($signed(coef[ACC_IDX_SELF_OFFSET_VALUE])),
      .difference (selfSub)
   );

   // Stage 2: self gain for the active amplifier setting.
   acc_gain_mult u_selfGain
   (
      .sample (s1.data),
      .gain   (selfGain),
      .scaled (selfScaled)
   );

   // Stage 3: selected system offset.
   acc_sat_sub u_sysSub
   (
      .minuend    (s2.data),
      .subtrahend (sysOffsetSel),
      .difference (sysSub)
   );

   // Stage 4: selected system gain.
   acc_gain_mult u_sysGain
   (
      .sample (s3.data),
      .gain   (sysGainSel),
      .scaled (sysScaled)
   );

   always_comb
   begin
      // Offsets are signed fields; the cast is the only interpretation used.
      sysOffsetSel = $signed(systemOffsetFirst);
      if (s2.choice == ACC_SEL_SET_SECOND)
         sysOffsetSel = $signed(coef[ACC_IDX_SYSTEM_OFFSET_SECOND]);
      sysGainSel = coef[ACC_IDX_SYSTEM_GAIN_FIRST];
      if (s3.choice == ACC_SEL_SET_SECOND)
         sysGainSel = coef[ACC_IDX_SYSTEM_GAIN_SECOND];
   end

   always_comb
   begin
      next_s1          = '0;
      next_s1.valid    = rawValid;
      next_s1.choice   = resultSlotCoefficientChoice;
      next_s1.unipolar = unipolarBipolarSelect;
      next_s1.data     = selfOffsetBypass ? rawData : selfSub;

      next_s2      = s1;
      next_s2.data = selfScaled;

      // Codes with the upper bit set leave only self calibration in effect.
      next_s3 = s2;
      if (!s2.choice[ACC_SEL_OFF_BIT])
         next_s3.data = sysSub;

      next_s4 = s3;
      if (!s3.choice[ACC_SEL_OFF_BIT])
         next_s4.data = sysScaled;

      // Polarity scaling comes last, after every offset has been removed.
      doubled          = acc_wide_t'(s4.data) <<< ACC_UNIPOLAR_SHIFT;
      next_resultValid = s4.valid;
      next_result      = s4.data;
      if (s4.unipolar == ACC_UNIPOLAR)
         next_result = acc_saturate(doubled);
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1          <= '0;
         s2          <= '0;
         s3          <= '0;
         s4          <= '0;
         resultValid <= 1'b0;
         result      <= ACC_SAMPLE_ZERO;
      end
      else
      begin
         s1          <= next_s1;
         s2          <= next_s2;
         s3          <= next_s3;
         s4          <= next_s4;
         resultValid <= next_resultValid;
         result      <= next_result;
      end
   end

   // Checks on the design's own behaviour.
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   chk_result_latency: assert property
      (rawValid |-> ##5 resultValid)
      else $error("Result valid did not follow the raw sample after five cycles.");

   chk_soff2_write: assert property
      (regWrEn && !calWrEn && regAddr == ACC_ADDR_SYSTEM_OFFSET_SECOND
       |=> coef[ACC_IDX_SYSTEM_OFFSET_SECOND] == $past(regWrData))
      else $error("Software write to the second system offset was not stored.");

   chk_cal_overwrite: assert property
      (calWrEn && calWrAddr == ACC_ADDR_SYSTEM_GAIN_FIRST
       |=> coef[ACC_IDX_SYSTEM_GAIN_FIRST] == $past(calWrData))
      else $error("Calibration load did not replace the first system gain.");

   chk_coef_hold: assert property
      (!(regWrEn && regAddr == ACC_ADDR_SELF_OFFSET_VALUE)
       && !(calWrEn && calWrAddr == ACC_ADDR_SELF_OFFSET_VALUE)
       |=> $stable(coef[ACC_IDX_SELF_OFFSET_VALUE]))
      else $error("Self offset changed without a write or calibration.");

   chk_bypass_pass: assert property
      (rawValid && selfOffsetBypass |=> s1.data == $past(rawData))
      else $error("Self offset was applied while bypassed.");

   chk_self_sub: assert property
      (rawValid && !selfOffsetBypass
       |=> s1.data == acc_saturate(acc_wide_t'($past(rawData))
                      - acc_wide_t'($signed($past(coef[ACC_IDX_SELF_OFFSET_VALUE])))))
      else $error("Self offset subtraction gave a wrong value.");

   chk_sys_disabled: assert property
      (s2.valid && s2.choice[ACC_SEL_OFF_BIT] |-> ##2 s4.data == $past(s2.data, 2))
      else $error("System correction was applied with calibration disabled.");

   chk_unity_gain: assert property
      (s3.valid && s3.choice == ACC_SEL_SET_FIRST
       && coef[ACC_IDX_SYSTEM_GAIN_FIRST] == ACC_GAIN_UNITY |=> s4.data == $past(s3.data))
      else $error("Unity system gain altered the sample.");

   chk_bipolar_pass: assert property
      (s4.valid && s4.unipolar != ACC_UNIPOLAR |=> result == $past(s4.data))
      else $error("Bipolar result was scaled.");

   chk_unipolar_clamp: assert property
      (s4.valid && s4.unipolar == ACC_UNIPOLAR && s4.data > (ACC_SAMPLE_MAX >>> 1)
       |=> result == ACC_SAMPLE_MAX)
      else $error("Unipolar doubling did not saturate at full scale.");

   chk_read_valid: assert property
      (regRdEn |=> regRdValid)
      else $error("Read strobe gave no read valid on the next cycle.");

   chk_read_unmapped: assert property
      (regRdEn && (regAddr < ACC_ADDR_SYSTEM_OFFSET_SECOND || regAddr > ACC_ADDR_SELF_OFFSET_VALUE)
       |=> regRdData == ACC_READ_UNMAPPED)
      else $error("Unmapped read returned a nonzero value.");

   chk_soff2_sub: assert property
      (s2.valid && s2.choice == ACC_SEL_SET_SECOND
       |=> s3.data == acc_saturate(acc_wide_t'($past(s2.data))
                      - acc_wide_t'($signed($past(coef[ACC_IDX_SYSTEM_OFFSET_SECOND])))))
      else $error("Second system offset was not subtracted for set B.");

   chk_gain2_scale: assert property
      (s3.valid && s3.choice == ACC_SEL_SET_SECOND
       |=> s4.data == acc_saturate((acc_wide_t'($past(s3.data))
                      * acc_wide_t'($signed({1'b0, $past(coef[ACC_IDX_SYSTEM_GAIN_SECOND])}))) >>> ACC_FRAC_W))
      else $error("Second system gain was not applied for set B.");

   chk_unipolar_double: assert property
      (s4.valid && s4.unipolar == ACC_UNIPOLAR && s4.data <= (ACC_SAMPLE_MAX >>> 1)
       && s4.data >= (ACC_SAMPLE_MIN >>> 1) |=> result == $past(s4.data) + $past(s4.data))
      else $error("Unipolar result was not twice the corrected sample.");

   cov_set_second:  cover property (s3.valid && s3.choice == ACC_SEL_SET_SECOND);
   cov_sys_off:     cover property (s3.valid && s3.choice[ACC_SEL_OFF_BIT]);
   cov_unipolar:    cover property (resultValid && $past(s4.unipolar) == ACC_UNIPOLAR);
   cov_cal_and_sw:  cover property (calWrEn && regWrEn && calWrAddr == regAddr);

endmodule // acc_correction

//--- hdl/acc_pkg.sv
// Purpose: Shared constants, types and saturation helper for the calibration correction block.
// Assumes: 24-bit two's complement samples and 1.23 unsigned gain coefficients.
// Notes:   Every data width, register offset and coefficient reset value used by the design is named here.
package acc_pkg;

   localparam int ACC_DATA_W   = 24;
   localparam int ACC_FRAC_W   = 23;
   localparam int ACC_WIDE_W   = 2 * ACC_DATA_W + 1;
   localparam int ACC_ADDR_W   = 8;
   localparam int ACC_NUM_COEF = 4;
   localparam int ACC_LATENCY  = 5;

   typedef logic signed [ACC_DATA_W-1:0] acc_sample_t;
   typedef logic        [ACC_DATA_W-1:0] acc_coef_t;
   typedef logic signed [ACC_WIDE_W-1:0] acc_wide_t;
   typedef logic        [ACC_ADDR_W-1:0] acc_addr_t;

   typedef struct packed {
      logic        valid;
      acc_sample_t data;
      logic [1:0]  choice;
      logic        unipolar;
   } acc_stage_t;

   // Register map; the coefficient index is the byte offset minus the base.
   localparam acc_addr_t ACC_ADDR_SYSTEM_OFFSET_SECOND = 8'h14;
   localparam acc_addr_t ACC_ADDR_SYSTEM_GAIN_FIRST    = 8'h15;
   localparam acc_addr_t ACC_ADDR_SYSTEM_GAIN_SECOND   = 8'h16;
   localparam acc_addr_t ACC_ADDR_SELF_OFFSET_VALUE    = 8'h17;
   localparam acc_addr_t ACC_ADDR_BASE                 = ACC_ADDR_SYSTEM_OFFSET_SECOND;

   localparam int ACC_IDX_SYSTEM_OFFSET_SECOND = 0;
   localparam int ACC_IDX_SYSTEM_GAIN_FIRST    = 1;
   localparam int ACC_IDX_SYSTEM_GAIN_SECOND   = 2;
   localparam int ACC_IDX_SELF_OFFSET_VALUE    = 3;

   localparam acc_coef_t   ACC_OFFSET_RESET  = 24'h000000;
   localparam acc_coef_t   ACC_GAIN_UNITY    = 24'h800000;
   localparam acc_coef_t   ACC_READ_UNMAPPED = 24'h000000;
   localparam acc_sample_t ACC_SAMPLE_MAX    = 24'sh7FFFFF;
   localparam acc_sample_t ACC_SAMPLE_MIN    = 24'sh800000;
   localparam acc_sample_t ACC_SAMPLE_ZERO   = 24'sh000000;

   localparam logic [1:0] ACC_SEL_SET_FIRST  = 2'h0;
   localparam logic [1:0] ACC_SEL_SET_SECOND = 2'h1;
   localparam int         ACC_SEL_OFF_BIT    = 1;
   localparam logic       ACC_UNIPOLAR       = 1'h1;
   localparam int         ACC_UNIPOLAR_SHIFT = 1;

   // Clamps a wide intermediate to the 24-bit signed output range.
   function automatic acc_sample_t acc_saturate(input acc_wide_t value);
      acc_sample_t clamped;
      if (value > acc_wide_t'(ACC_SAMPLE_MAX))
         clamped = ACC_SAMPLE_MAX;
      else if (value < acc_wide_t'(ACC_SAMPLE_MIN))
         clamped = ACC_SAMPLE_MIN;
      else
         clamped = value[ACC_DATA_W-1:0];
      return clamped;
   endfunction

endpackage

//--- hdl/acc_sat_sub.sv
// Purpose: Saturating subtraction of a two's complement offset from a sample.
// Assumes: Both operands are 24-bit two's complement, whatever the output coding.
// Notes:   Purely combinational; the caller registers the result.
`timescale 1ns/100ps
module acc_sat_sub
(
   input  wire logic signed [acc_pkg::ACC_DATA_W-1:0] minuend,
   input  wire logic signed [acc_pkg::ACC_DATA_W-1:0] subtrahend,
   output logic      signed [acc_pkg::ACC_DATA_W-1:0] difference
);
   import acc_pkg::*;

   acc_wide_t wideDiff;

   always_comb
   begin
      wideDiff   = acc_wide_t'(minuend) - acc_wide_t'(subtrahend);
      difference = acc_saturate(wideDiff);
   end

endmodule // acc_sat_sub

//--- hdl/acc_gain_mult.sv
// Purpose: Scales a signed sample by an unsigned 1.23 fixed-point gain.
// Assumes: Gain weighs one at its top bit and two to the minus 23 at its lowest.
// Notes:   Fraction bits are dropped by an arithmetic shift, so rounding is always toward minus infinity.
`timescale 1ns/100ps
module acc_gain_mult
(
   input  wire logic signed [acc_pkg::ACC_DATA_W-1:0] sample,
   input  wire logic        [acc_pkg::ACC_DATA_W-1:0] gain,
   output logic      signed [acc_pkg::ACC_DATA_W-1:0] scaled
);
   import acc_pkg::*;

   acc_wide_t product;
   acc_wide_t shifted;

   always_comb
   begin
      // A zero is prepended so the gain stays unsigned inside a signed product.
      product = acc_wide_t'(sample) * acc_wide_t'($signed({1'b0, gain}));
      shifted = product >>> ACC_FRAC_W;
      scaled  = acc_saturate(shifted);
   end

endmodule // acc_gain_mult

//--- sim/tb.sv
// Purpose: Self-checking bench for the calibration correction block.
// Assumes: Contract latencies of one cycle for reads and five for samples.
// Notes:   Coefficients stay still while samples are in flight, since each stage reads them live.
`timescale 1ns/100ps
module tb;
   import acc_pkg::*;

   typedef struct {
      acc_sample_t raw;
      logic [1:0]  ch;
      logic        uni;
      logic        byp;
      acc_sample_t exp;
   } acc_row_t;

   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   acc_addr_t   regAddr = 8'h00;
   logic        regWrEn = 1'b0;
   acc_coef_t   regWrData = 24'h000000;
   logic        regRdEn = 1'b0;
   acc_coef_t   regRdData;
   logic        regRdValid;
   logic        calWrEn = 1'b0;
   acc_addr_t   calWrAddr = 8'h00;
   acc_coef_t   calWrData = 24'h000000;
   acc_coef_t   systemOffsetFirst = 24'h000020;
   acc_coef_t   selfGain = 24'h800000;
   logic [1:0]  choice = 2'h0;
   logic        uni = 1'b0;
   logic        byp = 1'b0;
   logic        rawValid = 1'b0;
   acc_sample_t rawData = 24'sh000000;
   logic        resultValid;
   acc_sample_t result;
   int          mismatches = 0;
   int          cmp_count = 0;
   acc_row_t    rows [10];

   always #2 clk = ~clk;

   acc_correction dut_u (
      .clk                         (clk),
      .rst_n                       (rst_n),
      .regAddr                     (regAddr),
      .regWrEn                     (regWrEn),
      .regWrData                   (regWrData),
      .regRdEn                     (regRdEn),
      .regRdData                   (regRdData),
      .regRdValid                  (regRdValid),
      .calWrEn                     (calWrEn),
      .calWrAddr                   (calWrAddr),
      .calWrData                   (calWrData),
      .systemOffsetFirst           (systemOffsetFirst),
      .selfGain                    (selfGain),
      .resultSlotCoefficientChoice (choice),
      .unipolarBipolarSelect       (uni),
      .selfOffsetBypass            (byp),
      .rawValid                    (rawValid),
      .rawData                     (rawData),
      .resultValid                 (resultValid),
      .result                      (result)
   );

   task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
      cmp_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic regWrite(input acc_addr_t a, input acc_coef_t d);
      @(negedge clk);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      @(negedge clk);
      regWrEn = 1'b0;
   endtask

   task automatic calLoad(input acc_addr_t a, input acc_coef_t d);
      @(negedge clk);
      calWrAddr = a;
      calWrData = d;
      calWrEn = 1'b1;
      @(negedge clk);
      calWrEn = 1'b0;
   endtask

   task automatic regRead(input acc_addr_t a, input acc_coef_t exp);
      @(negedge clk);
      regAddr = a;
      regRdEn = 1'b1;
      @(negedge clk);
      regRdEn = 1'b0;
      check({23'h0, regRdValid}, 24'h000001, "read valid");
      check(regRdData, exp, "read data");
   endtask

   // Drives one sample and looks at the result five rising edges after it is driven.
   task automatic sendOne(input acc_row_t r);
      @(negedge clk);
      rawData = r.raw;
      choice = r.ch;
      uni = r.uni;
      byp = r.byp;
      rawValid = 1'b1;
      @(negedge clk);
      rawValid = 1'b0;
      repeat (4) @(negedge clk);
      check({23'h0, resultValid}, 24'h000001, "result valid");
      check(result, r.exp, "result");
   endtask

   initial
   begin
      rows = '{
         '{24'sh000100, 2'h0, 1'b0, 1'b0, 24'sh000068},
         '{24'sh000100, 2'h1, 1'b0, 1'b0, 24'sh000180},
         '{24'sh000100, 2'h2, 1'b0, 1'b0, 24'sh0000F0},
         '{24'sh000100, 2'h3, 1'b1, 1'b0, 24'sh0001E0},
         '{24'sh000100, 2'h2, 1'b0, 1'b1, 24'sh000100},
         '{24'sh000100, 2'h0, 1'b1, 1'b0, 24'sh0000D0},
         '{24'shFFFEFF, 2'h0, 1'b0, 1'b0, 24'shFFFF67},
         '{24'sh7FFFF0, 2'h1, 1'b0, 1'b1, 24'sh7FFFFF},
         '{24'sh400000, 2'h2, 1'b1, 1'b1, 24'sh7FFFFF},
         '{24'sh800000, 2'h2, 1'b0, 1'b0, 24'sh800000}};
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      regRead(8'h14, 24'h000000);
      regRead(8'h15, 24'h800000);
      regRead(8'h16, 24'h800000);
      regRead(8'h17, 24'h000000);
      regRead(8'h13, 24'h000000);
      regWrite(8'h18, 24'h5A5A5A);
      regRead(8'h18, 24'h000000);
      regWrite(8'h17, 24'h000010);
      regWrite(8'h14, 24'hFFFFF0);
      regWrite(8'h15, 24'h400000);
      regWrite(8'h16, 24'hC00000);
      regRead(8'h14, 24'hFFFFF0);
      regRead(8'h16, 24'hC00000);
      // Rows go in back to back so that every pipeline stage holds a different sample.
      fork
         begin
            for (int i = 0; i < 10; i++)
            begin
               @(negedge clk);
               rawData = rows[i].raw;
               choice = rows[i].ch;
               uni = rows[i].uni;
               byp = rows[i].byp;
               rawValid = 1'b1;
            end
            @(negedge clk);
            rawValid = 1'b0;
         end
         begin
            repeat (6) @(negedge clk);
            for (int i = 0; i < 10; i++)
            begin
               check({23'h0, resultValid}, 24'h000001, "row valid");
               check(result, rows[i].exp, "row result");
               @(negedge clk);
            end
            check({23'h0, resultValid}, 24'h000000, "valid after burst");
         end
      join
      regRead(8'h17, 24'h000010);
      regRead(8'h15, 24'h400000);
      regRead(8'h14, 24'hFFFFF0);
      selfGain = 24'h400000;
      sendOne('{24'sh000100, 2'h0, 1'b0, 1'b0, 24'sh00002C});
      selfGain = 24'h800000;
      systemOffsetFirst = 24'h000000;
      // Calibration and software hit the same register in one cycle; calibration must win.
      @(negedge clk);
      regAddr = 8'h15;
      regWrData = 24'h123456;
      regWrEn = 1'b1;
      calWrAddr = 8'h15;
      calWrData = 24'hFFFFFF;
      calWrEn = 1'b1;
      @(negedge clk);
      regWrEn = 1'b0;
      calWrEn = 1'b0;
      regRead(8'h15, 24'hFFFFFF);
      sendOne('{24'sh100000, 2'h0, 1'b0, 1'b1, 24'sh1FFFFF});
      calLoad(8'h17, 24'h000005);
      regRead(8'h17, 24'h000005);
      calLoad(8'h14, 24'h000007);
      regRead(8'h14, 24'h000007);
      calLoad(8'h16, 24'h200000);
      regRead(8'h16, 24'h200000);
      @(negedge clk);
      rst_n = 1'b0;
      @(negedge clk);
      check({23'h0, resultValid}, 24'h000000, "valid in reset");
      check(result, 24'h000000, "result in reset");
      check({23'h0, regRdValid}, 24'h000000, "read valid in reset");
      rst_n = 1'b1;
      regRead(8'h15, 24'h800000);
      regRead(8'h14, 24'h000000);
      // Unity gains and zero offsets after reset must pass the sample through untouched.
      sendOne('{24'sh123456, 2'h0, 1'b0, 1'b0, 24'sh123456});
      summarize();
   end

   // A hung run is cut short here and reported as a failure.
   initial
   begin
      repeat (20000) @(posedge clk);
      mismatches++;
      summarize();
   end

endmodule // tb
